/* verilog/mscr_defs.vh */
/*
 * Shared constants of the status and system control register bank:
 * data memory addresses, field positions, reset values and ALU op codes.
 * Assumes it is included by bare name from the design files only.
 */
`ifndef MSCR_DEFS_VH
`define MSCR_DEFS_VH

// data memory addresses of the special function registers
`define MSCR_ADDR_PC_LOW        7'h06
`define MSCR_ADDR_STATUS        7'h0A
`define MSCR_ADDR_PORT_A_DATA   7'h10
`define MSCR_ADDR_PORT_A_DIR    7'h11
`define MSCR_ADDR_PORT_A_PULLUP 7'h12
`define MSCR_ADDR_PORT_A_WAKE   7'h13
`define MSCR_ADDR_PORT_B_DATA   7'h14
`define MSCR_ADDR_PORT_B_DIR    7'h15
`define MSCR_ADDR_PORT_B_PULLUP 7'h16
`define MSCR_ADDR_CTRL_A        7'h1A
`define MSCR_ADDR_CTRL_B        7'h1B

// status register fields
`define MSCR_ST_CARRY     0
`define MSCR_ST_AUX_CARRY 1
`define MSCR_ST_ZERO      2
`define MSCR_ST_OVERFLOW  3
`define MSCR_ST_POWER_DN  4
`define MSCR_ST_TIMEOUT   5
`define MSCR_ST_WR_MASK   8'h0F

// system control a fields and writable masks per variant
`define MSCR_CA_SYSCLK_SRC  0
`define MSCR_CA_SLOW_XTL_LP 1
`define MSCR_CA_DIV_PIN     2
`define MSCR_CA_PWM_PIN     3
`define MSCR_CA_PWM_TYPE    5
`define MSCR_CA_DIV_SRC     6
`define MSCR_CA_MASK_FULL   8'h6F
`define MSCR_CA_MASK_RED    8'h47

// system control b fields
`define MSCR_CB_WD_LSB      0
`define MSCR_CB_TB_LSB      4
`define MSCR_CB_EDGE_LSB    6
`define MSCR_WD_OFF_CODE    4'hA
`define MSCR_TB_BASE_LOG2   4'hA

// reset values
`define MSCR_RST_STATUS     8'h00
`define MSCR_RST_CTRL_A     8'h00
`define MSCR_RST_CTRL_B     8'h8A
`define MSCR_RST_DIR        8'hFF
`define MSCR_RST_ZERO       8'h00

// ALU flag operations
`define MSCR_OP_ADD   3'h0
`define MSCR_OP_ADDC  3'h1
`define MSCR_OP_SUB   3'h2
`define MSCR_OP_SUBC  3'h3
`define MSCR_OP_LOGIC 3'h4
`define MSCR_OP_RRC   3'h5
`define MSCR_OP_RLC   3'h6

`endif

/* verilog/mscr_alu_flags.v */
/*
 * Combinational flag generator for the arithmetic status bits.
 * Assumes the caller registers the outputs and passes the logic
 * result on op_b for logic operations.
 */
`timescale 1ns/100ps
`include "mscr_defs.vh"

module mscr_alu_flags (
    input  wire [2:0] op,          // operation code
    input  wire [7:0] op_a,        // first operand
    input  wire [7:0] op_b,        // second operand or logic result
    input  wire       carry_in,    // current carry flag
    output reg  [7:0] result,      // operation result
    output reg  [3:0] flags,       // overflow, zero, aux carry, carry
    output reg  [3:0] flag_upd     // which of the flags update
);
    reg  [7:0] rhs;
    reg        cin;
    reg  [4:0] low_sum;
    reg  [7:0] low7_sum;
    reg  [8:0] full_sum;

    always @* begin
        rhs      = op_b;
        cin      = 1'b0;
        result   = op_b;
        flags    = 4'h0;
        flag_upd = 4'h0;
        case (op)
            `MSCR_OP_ADD:  cin = 1'b0;
            `MSCR_OP_ADDC: cin = carry_in;
            `MSCR_OP_SUB: begin
                rhs = ~op_b;
                cin = 1'b1;
            end
            `MSCR_OP_SUBC: begin
                rhs = ~op_b;
                cin = carry_in;
            end
            default: cin = 1'b0;
        endcase
        low_sum  = {1'b0, op_a[3:0]} + {1'b0, rhs[3:0]} + {4'h0, cin};
        low7_sum = {1'b0, op_a[6:0]} + {1'b0, rhs[6:0]} + {7'h00, cin};
        full_sum = {1'b0, op_a} + {1'b0, rhs} + {8'h00, cin};
        case (op)
            `MSCR_OP_ADD, `MSCR_OP_ADDC, `MSCR_OP_SUB, `MSCR_OP_SUBC: begin
                result   = full_sum[7:0];
                flags[0] = full_sum[8];
                flags[1] = low_sum[4];
                flags[2] = (full_sum[7:0] == 8'h00);
                flags[3] = low7_sum[7] ^ full_sum[8];
                flag_upd = 4'hF;
            end
            `MSCR_OP_LOGIC: begin
                result   = op_b;
                flags[2] = (op_b == 8'h00);
                flag_upd = 4'h4;
            end
            `MSCR_OP_RRC: begin
                result   = {carry_in, op_a[7:1]};
                flags[0] = op_a[0];
                flag_upd = 4'h1;
            end
            `MSCR_OP_RLC: begin
                result   = {op_a[6:0], carry_in};
                flags[0] = op_a[7];
                flag_upd = 4'h1;
            end
            default: flag_upd = 4'h0;
        endcase
    end
endmodule // mscr_alu_flags

/* verilog/mscr_regs.v */
/*
 * Status and system control special function registers of the core:
 * program counter low byte, status flags, port direction, pull-high and
 * wake select, and the two system control registers with their decodes.
 * Assumes the core drives one data memory access per cycle on ref_clk,
 * reports instruction events as one-cycle pulses, and that pins are
 * asynchronous to ref_clk.
 */
// Notes on behaviour
// - writing counter low byte jumps within page
// - counter low write inserts one dummy cycle
// - status writes never touch timeout, power-down
// - timeout set by watchdog, cleared by power-up/instructions
// - power-down set by halt, cleared by power-up/clear watchdog
// - status not pushed on call or interrupt
// - top status bits zero; flags zero at reset
// - overflow is carry-in xor carry-out of msb
// - zero flag marks zero result
// - aux carry from low nibble, no-borrow sense
// - carry from add, no-borrow, or rotates
// - direction bit one input, zero output
// - wake select picks falling-edge wake pins
// - pull-up only while pin is input
// - divider source timer0/1 and pin use
// - pwm pin use, type, system timer clock
// - slow crystal quick start or low power
// - system clock source, only in combo config
// - reduced variant bits five to three zero
// - external interrupt edge decode
// - time-base period two to ten..thirteen
// - watchdog off only option off and 1010
`timescale 1ns/100ps
`include "mscr_defs.vh"

module mscr_regs #(
    parameter FULL_VARIANT = 1                 // 1: pwm and adc variant
) (
    input  wire       ref_clk,                 // system clock, 25 MHz
    input  wire       sys_rst,                 // power-on reset, sync, high
    input  wire [6:0] mem_addr,                // data memory address
    input  wire       mem_wr,                  // write strobe
    input  wire       mem_rd,                  // read strobe
    input  wire [7:0] mem_wdata,               // write data
    output reg  [7:0] rd_data_r,               // read data, next cycle
    output reg        rd_hit_r,                // read hit a register here
    input  wire [7:0] pc_low_cur,              // current counter low byte
    output reg        pc_low_load_r,           // load counter low byte
    output reg  [7:0] pc_low_value_r,          // new counter low byte
    output reg        dummy_cycle_r,           // insert one dummy cycle
    input  wire       alu_valid,               // alu operation this cycle
    input  wire [2:0] alu_op,                  // alu operation code
    input  wire [7:0] alu_a,                   // alu operand a
    input  wire [7:0] alu_b,                   // alu operand b
    output reg  [7:0] alu_result_r,            // alu result
    output reg        alu_done_r,              // alu result valid
    input  wire       watchdog_timeout,        // watchdog time-out pulse
    input  wire       clear_watchdog_exec,     // clear watchdog instr pulse
    input  wire       halt_exec,               // halt instruction pulse
    input  wire       sleep_mode,              // core is asleep
    input  wire       cfg_watchdog_opt,        // watchdog always-on option
    input  wire       cfg_fast_slow_combo,     // fast osc plus slow crystal
    input  wire [7:0] port_a_pin_in,           // port a pin levels
    output reg  [7:0] port_a_out_r,            // port a pin drive
    output reg  [7:0] port_a_oe_r,             // port a output enable
    output reg  [7:0] port_a_pullup_r,         // port a pull-up enable
    input  wire [1:0] port_b_pin_in,           // port b pin levels
    output reg  [1:0] port_b_out_r,            // port b pin drive
    output reg  [1:0] port_b_oe_r,             // port b output enable
    output reg  [1:0] port_b_pullup_r,         // port b pull-up enable
    output reg        wake_req_r,              // wake from sleep pulse
    output reg  [7:0] status_r,                // status register
    output reg        divider_source_timer1_r, // divider clocked by timer1
    output reg        divider_pin_en_r,        // divider output on pin
    output reg        pwm_pin_en_r,            // pwm output on pin
    output reg        pwm_type_7p1_r,          // pwm 7+1 type
    output reg        timer_clk_from_sys_r,    // timer clock is system clock
    output reg        slow_crystal_lp_r,       // slow crystal low power
    output reg        sysclk_slow_r,           // slow crystal runs system
    output reg        fast_osc_stop_r,         // stop fast oscillator
    output reg        ext_irq_rise_en_r,       // irq on rising edge
    output reg        ext_irq_fall_en_r,       // irq on falling edge
    output reg  [3:0] timebase_log2_r,         // time-base period exponent
    output reg        watchdog_enabled_r       // watchdog running
);
    localparam [7:0] CTRL_A_MASK = (FULL_VARIANT != 0) ? `MSCR_CA_MASK_FULL
                                                       : `MSCR_CA_MASK_RED;

    reg  [7:0] ctrl_a_r;
    reg  [7:0] ctrl_b_r;
    reg  [7:0] port_a_dir_r;
    reg  [7:0] port_a_pu_sel_r;
    reg  [7:0] port_a_wake_sel_r;
    reg  [7:0] port_a_latch_r;
    reg  [1:0] port_b_dir_r;
    reg  [1:0] port_b_pu_sel_r;
    reg  [1:0] port_b_latch_r;
    reg  [7:0] pa_meta_r;
    reg  [7:0] pa_sync_r;
    reg  [7:0] pa_prev_r;
    reg  [1:0] pb_meta_r;
    reg  [1:0] pb_sync_r;
    reg  [7:0] status_nxt;
    reg  [7:0] rd_data_nxt;
    reg        rd_hit_nxt;
    wire [7:0] alu_result;
    wire [3:0] alu_flags;
    wire [3:0] alu_upd;
    wire [7:0] pa_fall;
    wire [7:0] pa_read;
    wire [1:0] pb_read;
    wire       wr_pc_low;
    wire       wr_status;
    wire       ca_wr;
    wire       cb_wr;

    assign wr_pc_low = mem_wr && (mem_addr == `MSCR_ADDR_PC_LOW);
    assign wr_status = mem_wr && (mem_addr == `MSCR_ADDR_STATUS);
    assign ca_wr     = mem_wr && (mem_addr == `MSCR_ADDR_CTRL_A);
    assign cb_wr     = mem_wr && (mem_addr == `MSCR_ADDR_CTRL_B);

    mscr_alu_flags u_flags (
        .op       (alu_op),
        .op_a     (alu_a),
        .op_b     (alu_b),
        .carry_in (status_r[`MSCR_ST_CARRY]),
        .result   (alu_result),
        .flags    (alu_flags),
        .flag_upd (alu_upd)
    );

    // counter low byte: the core owns the upper bits, so only the low
    // byte is replaced and the jump stays inside the current page
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            pc_low_load_r  <= 1'b0;
            pc_low_value_r <= 8'h00;
            dummy_cycle_r  <= 1'b0;
        end else begin
            pc_low_load_r  <= wr_pc_low;
            dummy_cycle_r  <= wr_pc_low;
            if (wr_pc_low) begin
                pc_low_value_r <= mem_wdata;
            end
        end
    end

    // status next value; the register has no stack path, software saves it
    always @* begin
        status_nxt = status_r;
        if (alu_valid) begin
            if (alu_upd[0]) status_nxt[`MSCR_ST_CARRY]     = alu_flags[0];
            if (alu_upd[1]) status_nxt[`MSCR_ST_AUX_CARRY] = alu_flags[1];
            if (alu_upd[2]) status_nxt[`MSCR_ST_ZERO]      = alu_flags[2];
            if (alu_upd[3]) status_nxt[`MSCR_ST_OVERFLOW]  = alu_flags[3];
        end
        // an explicit write to the register beats flags of the same cycle
        if (wr_status) begin
            status_nxt = (status_nxt & ~`MSCR_ST_WR_MASK) | (mem_wdata & `MSCR_ST_WR_MASK);
        end
        if (clear_watchdog_exec || halt_exec) begin
            status_nxt[`MSCR_ST_TIMEOUT] = 1'b0;
        end
        if (watchdog_timeout) begin
            status_nxt[`MSCR_ST_TIMEOUT] = 1'b1;
        end
        if (clear_watchdog_exec) begin
            status_nxt[`MSCR_ST_POWER_DN] = 1'b0;
        end
        if (halt_exec) begin
            status_nxt[`MSCR_ST_POWER_DN] = 1'b1;
        end
        status_nxt[7:6] = 2'b00;
    end

    always @(posedge ref_clk) begin
        if (sys_rst) begin
            status_r     <= `MSCR_RST_STATUS;
            alu_result_r <= 8'h00;
            alu_done_r   <= 1'b0;
        end else begin
            status_r     <= status_nxt;
            alu_done_r   <= alu_valid;
            if (alu_valid) begin
                alu_result_r <= alu_result;
            end
        end
    end

    // configuration registers written by the core
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl_a_r          <= `MSCR_RST_CTRL_A;
            ctrl_b_r          <= `MSCR_RST_CTRL_B;
            port_a_dir_r      <= `MSCR_RST_DIR;
            port_b_dir_r      <= 2'b11;
            port_a_pu_sel_r   <= `MSCR_RST_ZERO;
            port_b_pu_sel_r   <= 2'b00;
            port_a_wake_sel_r <= `MSCR_RST_ZERO;
            port_a_latch_r    <= `MSCR_RST_ZERO;
            port_b_latch_r    <= 2'b00;
        end else if (mem_wr) begin
            case (mem_addr)
                `MSCR_ADDR_CTRL_A:        ctrl_a_r <= mem_wdata & CTRL_A_MASK;
                `MSCR_ADDR_CTRL_B:        ctrl_b_r <= mem_wdata;
                `MSCR_ADDR_PORT_A_DIR:    port_a_dir_r <= mem_wdata;
                `MSCR_ADDR_PORT_B_DIR:    port_b_dir_r <= mem_wdata[1:0];
                `MSCR_ADDR_PORT_A_PULLUP: port_a_pu_sel_r <= mem_wdata;
                `MSCR_ADDR_PORT_B_PULLUP: port_b_pu_sel_r <= mem_wdata[1:0];
                `MSCR_ADDR_PORT_A_WAKE:   port_a_wake_sel_r <= mem_wdata;
                `MSCR_ADDR_PORT_A_DATA:   port_a_latch_r <= mem_wdata;
                `MSCR_ADDR_PORT_B_DATA:   port_b_latch_r <= mem_wdata[1:0];
                default:                  ctrl_b_r <= ctrl_b_r;
            endcase
        end
    end

    // pins are asynchronous; two flops before anything reads them
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            pa_meta_r <= 8'h00;
            pa_sync_r <= 8'h00;
            pa_prev_r <= 8'h00;
            pb_meta_r <= 2'b00;
            pb_sync_r <= 2'b00;
        end else begin
            pa_meta_r <= port_a_pin_in;
            pa_sync_r <= pa_meta_r;
            pa_prev_r <= pa_sync_r;
            pb_meta_r <= port_b_pin_in;
            pb_sync_r <= pb_meta_r;
        end
    end

    // per pin: read source follows direction, port a falling edge feeds wake
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_port_a
            assign pa_read[gi] = port_a_dir_r[gi] ? pa_sync_r[gi]
                                                  : port_a_latch_r[gi];
            assign pa_fall[gi] = port_a_wake_sel_r[gi] & pa_prev_r[gi]
                                 & ~pa_sync_r[gi];
        end
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_port_b
            assign pb_read[gi] = port_b_dir_r[gi] ? pb_sync_r[gi]
                                                  : port_b_latch_r[gi];
        end
    endgenerate

    always @(posedge ref_clk) begin
        if (sys_rst) begin
            port_a_out_r    <= 8'h00;
            port_a_oe_r     <= 8'h00;
            port_a_pullup_r <= 8'h00;
            port_b_out_r    <= 2'b00;
            port_b_oe_r     <= 2'b00;
            port_b_pullup_r <= 2'b00;
            wake_req_r      <= 1'b0;
        end else begin
            port_a_out_r    <= port_a_latch_r;
            port_a_oe_r     <= ~port_a_dir_r;
            port_a_pullup_r <= port_a_pu_sel_r & port_a_dir_r;
            port_b_out_r    <= port_b_latch_r;
            port_b_oe_r     <= ~port_b_dir_r;
            port_b_pullup_r <= port_b_pu_sel_r & port_b_dir_r;
            wake_req_r      <= sleep_mode && (pa_fall != 8'h00);
        end
    end

    // decoded controls lag the register by one cycle to stay flop-driven
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            divider_source_timer1_r <= 1'b0;
            divider_pin_en_r        <= 1'b0;
            pwm_pin_en_r            <= 1'b0;
            pwm_type_7p1_r          <= 1'b0;
            timer_clk_from_sys_r    <= 1'b0;
            slow_crystal_lp_r       <= 1'b0;
            sysclk_slow_r           <= 1'b0;
            fast_osc_stop_r         <= 1'b0;
            ext_irq_rise_en_r       <= 1'b0;
            ext_irq_fall_en_r       <= 1'b0;
            timebase_log2_r         <= `MSCR_TB_BASE_LOG2;
            watchdog_enabled_r      <= 1'b1;
        end else begin
            divider_source_timer1_r <= ctrl_a_r[`MSCR_CA_DIV_SRC];
            divider_pin_en_r        <= ctrl_a_r[`MSCR_CA_DIV_PIN];
            pwm_pin_en_r            <= ctrl_a_r[`MSCR_CA_PWM_PIN];
            pwm_type_7p1_r          <= ctrl_a_r[`MSCR_CA_PWM_TYPE];
            timer_clk_from_sys_r    <= ctrl_a_r[`MSCR_CA_PWM_PIN];
            slow_crystal_lp_r       <= ctrl_a_r[`MSCR_CA_SLOW_XTL_LP];
            // clock source bit is ignored unless the combo config is fused
            sysclk_slow_r   <= ctrl_a_r[`MSCR_CA_SYSCLK_SRC] & cfg_fast_slow_combo;
            fast_osc_stop_r <= ctrl_a_r[`MSCR_CA_SYSCLK_SRC] & cfg_fast_slow_combo;
            ext_irq_rise_en_r <= ctrl_b_r[`MSCR_CB_EDGE_LSB];
            ext_irq_fall_en_r <= ctrl_b_r[`MSCR_CB_EDGE_LSB + 1];
            timebase_log2_r   <= `MSCR_TB_BASE_LOG2
                                 + {2'b00, ctrl_b_r[`MSCR_CB_TB_LSB +: 2]};
            watchdog_enabled_r <= cfg_watchdog_opt
                || (ctrl_b_r[`MSCR_CB_WD_LSB +: 4] != `MSCR_WD_OFF_CODE);
        end
    end

    // read mux; unmapped addresses answer zero and drop the hit flag
    always @* begin
        rd_data_nxt = 8'h00;
        rd_hit_nxt  = 1'b1;
        case (mem_addr)
            `MSCR_ADDR_PC_LOW:        rd_data_nxt = pc_low_cur;
            `MSCR_ADDR_STATUS:        rd_data_nxt = status_r;
            `MSCR_ADDR_CTRL_A:        rd_data_nxt = ctrl_a_r & CTRL_A_MASK;
            `MSCR_ADDR_CTRL_B:        rd_data_nxt = ctrl_b_r;
            `MSCR_ADDR_PORT_A_DIR:    rd_data_nxt = port_a_dir_r;
            `MSCR_ADDR_PORT_B_DIR:    rd_data_nxt = {6'h00, port_b_dir_r};
            `MSCR_ADDR_PORT_A_PULLUP: rd_data_nxt = port_a_pu_sel_r;
            `MSCR_ADDR_PORT_B_PULLUP: rd_data_nxt = {6'h00, port_b_pu_sel_r};
            `MSCR_ADDR_PORT_A_WAKE:   rd_data_nxt = port_a_wake_sel_r;
            `MSCR_ADDR_PORT_A_DATA:   rd_data_nxt = pa_read;
            `MSCR_ADDR_PORT_B_DATA:   rd_data_nxt = {6'h00, pb_read};
            default:                  rd_hit_nxt  = 1'b0;
        endcase
    end

    always @(posedge ref_clk) begin
        if (sys_rst) begin
            rd_data_r <= 8'h00;
            rd_hit_r  <= 1'b0;
        end else if (mem_rd) begin
            rd_data_r <= rd_data_nxt;
            rd_hit_r  <= rd_hit_nxt;
        end else begin
            rd_hit_r  <= 1'b0;
        end
    end
endmodule // mscr_regs

/* verification/mscr_core_model.sv */
/* core side model: holds the counter low byte and counts dummy cycles.
   assumes the register bank runs on the same ref_clk. */
`timescale 1ns/100ps
module mscr_core_model (
    input  wire       ref_clk,   // system clock
    input  wire       sys_rst,   // sync reset, high
    input  wire       load,      // counter low load pulse
    input  wire       dummy,     // dummy cycle pulse
    input  wire [7:0] value,     // new counter low byte
    output reg  [7:0] pc_low,    // current counter low byte
    output reg  [7:0] dummy_cnt  // dummy cycles seen
);
    // no status copy is kept on calls, software saves it
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            pc_low    <= 8'h00;
            dummy_cnt <= 8'h00;
        end else begin
            if (load) pc_low <= value;
            if (dummy) dummy_cnt <= dummy_cnt + 8'h01;
        end
    end
endmodule // mscr_core_model

/* verification/mscr_regs_chk.sv */
/* assertions on the status and control bank ports.
   assumes one clock domain and the bank's sync reset. */
`timescale 1ns/100ps
module mscr_regs_chk (
    input wire       ref_clk,             // system clock
    input wire       sys_rst,             // sync reset
    input wire [6:0] mem_addr,            // address
    input wire       mem_wr,              // write strobe
    input wire [7:0] mem_wdata,           // write data
    input wire       pc_low_load_r,       // counter load
    input wire [7:0] pc_low_value_r,      // counter value
    input wire       dummy_cycle_r,       // dummy cycle
    input wire       alu_valid,           // alu strobe
    input wire [2:0] alu_op,              // alu op
    input wire [7:0] alu_b,               // logic result
    input wire [7:0] status_r,            // status
    input wire       watchdog_timeout,    // timeout pulse
    input wire       clear_watchdog_exec, // clear pulse
    input wire       halt_exec            // halt pulse
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    wire ev_any = watchdog_timeout | clear_watchdog_exec | halt_exec;
    wire st_wr  = mem_wr && mem_addr == 7'h0A;
    a_pcl_jump: assert property (mem_wr && mem_addr == 7'h06 |=> pc_low_load_r
        && pc_low_value_r == $past(mem_wdata)) else $error("counter low not loaded");
    a_dummy_cycle: assert property (dummy_cycle_r == pc_low_load_r)
        else $error("dummy cycle not paired with load");
    a_status_top: assert property (status_r[7:6] == 2'h0) else $error("status top set");
    a_status_wr: assert property (st_wr |=> {4'h0, status_r[3:0]} ==
        ($past(mem_wdata) & 8'h0F)) else $error("status flags not written");
    a_flags_kept: assert property (!ev_any |=> $stable(status_r[5:4]))
        else $error("protected flags moved");
    a_timeout_set: assert property (watchdog_timeout |=> status_r[5])
        else $error("timeout flag not set");
    a_halt_flags: assert property (halt_exec && !watchdog_timeout |=>
        status_r[5:4] == 2'h1) else $error("halt flags wrong");
    a_clear_flags: assert property (clear_watchdog_exec && !halt_exec &&
        !watchdog_timeout |=> status_r[5:4] == 2'h0) else $error("clear flags wrong");
    a_zero_logic: assert property (alu_valid && alu_op == 3'h4 && !st_wr |=>
        status_r[2] == ($past(alu_b) == 8'h00)) else $error("zero flag wrong");
    c_load: cover property (pc_low_load_r);
    c_halt: cover property (halt_exec ##1 status_r[4]);
    c_sub: cover property (alu_valid && alu_op == 3'h2);
endmodule // mscr_regs_chk
bind mscr_regs mscr_regs_chk chk (.*);

/* verification/mscr_regs_tb_top.sv */
/* self-checking bench of the status and control bank.
   assumes the core model returns counter low. */
`timescale 1ns/100ps
module mscr_regs_tb_top;
    logic       ref_clk = 0, sys_rst = 1, mem_wr = 0, mem_rd = 0, alu_valid = 0, rd_pend = 0;
    logic       sleep = 0, wdo = 0, combo = 0;
    logic [6:0] mem_addr = 0;
    logic [7:0] mem_wdata = 0, alu_a = 0, alu_b = 0, pa_pin = 0, tmp;
    logic [2:0] alu_op = 0, ev = 0, op;
    logic [1:0] s54;
    logic [3:0] fl;
    logic [11:0] r;
    logic [7:0] exp_q[$];
    logic [6:0] ad[9] = '{7'h0A, 7'h1A, 7'h1B, 7'h11, 7'h12, 7'h13, 7'h15, 7'h16, 7'h17};
    logic [7:0] rv[9] = '{8'h00, 8'h00, 8'h8A, 8'hFF, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00};
    logic [7:0] mk[9] = '{8'h0F, 8'h6F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h03, 8'h03, 8'h00};
    wire  [7:0] rd_d, pcv, res, st, pa_o, pa_oe, pa_pu, pc_cur, dcnt;
    wire  [9:0] ctl;
    wire  [3:0] tbl;
    wire        hit, ld, dm, done, wk, wd_en;
    int         error_cnt = 0, checked = 0, seed = 32'h4a1a40fb, i;
    always #20 ref_clk = ~ref_clk;
    mscr_core_model core (.ref_clk, .sys_rst, .load(ld), .dummy(dm), .value(pcv),
        .pc_low(pc_cur), .dummy_cnt(dcnt));
    mscr_regs uut (.ref_clk, .sys_rst, .mem_addr, .mem_wr, .mem_rd, .mem_wdata,
        .rd_data_r(rd_d), .rd_hit_r(hit), .pc_low_cur(pc_cur), .pc_low_load_r(ld),
        .pc_low_value_r(pcv), .dummy_cycle_r(dm), .alu_valid, .alu_op, .alu_a, .alu_b,
        .alu_result_r(res), .alu_done_r(done), .watchdog_timeout(ev[2]),
        .clear_watchdog_exec(ev[1]), .halt_exec(ev[0]), .sleep_mode(sleep),
        .cfg_watchdog_opt(wdo), .cfg_fast_slow_combo(combo), .port_a_pin_in(pa_pin),
        .port_a_out_r(pa_o), .port_a_oe_r(pa_oe), .port_a_pullup_r(pa_pu),
        .port_b_pin_in(2'h0), .port_b_out_r(), .port_b_oe_r(), .port_b_pullup_r(),
        .wake_req_r(wk), .status_r(st), .divider_source_timer1_r(ctl[9]),
        .divider_pin_en_r(ctl[8]), .pwm_pin_en_r(ctl[7]), .pwm_type_7p1_r(ctl[6]),
        .timer_clk_from_sys_r(ctl[5]), .slow_crystal_lp_r(ctl[4]), .sysclk_slow_r(ctl[3]),
        .fast_osc_stop_r(ctl[2]), .ext_irq_rise_en_r(ctl[1]), .ext_irq_fall_en_r(ctl[0]),
        .timebase_log2_r(tbl), .watchdog_enabled_r(wd_en));
    task automatic complete_run;
        if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmp(input [15:0] g, input [15:0] e);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input [6:0] a, input [7:0] d);
        @(posedge ref_clk) {mem_wr, mem_addr, mem_wdata} <= {1'b1, a, d};
        @(posedge ref_clk) mem_wr <= 0;
        #1;
    endtask
    task automatic rd(input [6:0] a, input [7:0] e);
        @(posedge ref_clk) {mem_rd, mem_addr} <= {1'b1, a};
        exp_q.push_back(e);
        @(posedge ref_clk) mem_rd <= 0;
    endtask
    task automatic alu(input [2:0] o, input [7:0] a, input [7:0] b);
        @(posedge ref_clk) {alu_valid, alu_op, alu_a, alu_b} <= {1'b1, o, a, b};
        @(posedge ref_clk) alu_valid <= 0;
        #1;
    endtask
    task automatic pulse(input [2:0] v, input [1:0] e);
        @(posedge ref_clk) ev <= v;
        @(posedge ref_clk) ev <= 0;
        #1;
        cmp(st[5:4], e);
    endtask
    // subtraction is fed as a + ~b + carry, so carry reads as no borrow
    function automatic [11:0] ref_add(input [7:0] a, input [7:0] b, input c);
        logic [8:0] s;
        logic [7:0] s7;
        logic [4:0] h;
        s = a + b + c;
        s7 = a[6:0] + b[6:0] + c;
        h = a[3:0] + b[3:0] + c;
        ref_add = {s[7:0], s[8] ^ s7[7], s[7:0] == 8'h00, h[4], s[8]};
    endfunction
    always @(posedge ref_clk) rd_pend <= mem_rd;
    always @(negedge ref_clk) if (rd_pend) cmp(rd_d, exp_q.pop_front());
    initial begin
        #2000000;
        error_cnt++;
        complete_run();
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        sys_rst <= 0;
        for (i = 0; i < 9; i++) rd(ad[i], rv[i]);
        for (i = 0; i < 9; i++) begin
            tmp = $random(seed);
            wr(ad[i], tmp);
            rd(ad[i], tmp & mk[i]);
        end
        pulse(3'h1, 2'h1);
        wr(7'h0A, 8'hFF);
        rd(7'h0A, 8'h1F);
        pulse(3'h4, 2'h3);
        pulse(3'h2, 2'h0);
        pulse(3'h4, 2'h2);
        pulse(3'h1, 2'h1);
        s54 = 2'h1;
        fl = 4'hF;
        wr(7'h06, 8'h5C);
        cmp({ld, dm, pcv}, {2'h3, 8'h5C});
        rd(7'h06, 8'h5C);
        cmp(dcnt, 8'h01);
        for (i = 0; i < 12; i++) begin
            {op, alu_a, tmp} = {1'b0, 18'($random(seed))};
            r = ref_add(alu_a, op[1] ? ~tmp : tmp, op[0] ? fl[0] : op[1]);
            alu(op, alu_a, tmp);
            cmp({res, st}, {r[11:4], 2'h0, s54, r[3:0]});
            fl = r[3:0];
        end
        alu(3'h4, 8'h33, 8'h00);
        cmp(st[3:0], fl | 4'h4);
        alu(3'h6, 8'h80, 8'h00);
        cmp({res, st[3:0]}, {7'h00, fl[0], fl[3], 1'b1, fl[1], 1'b1});
        for (i = 0; i < 4; i++) begin
            wr(7'h1B, {i[1:0], i[1:0], (i == 0) ? 4'hA : 4'h5});
            @(posedge ref_clk) #1;
            cmp({ctl[1:0], tbl, wd_en}, {i[0], i[1], 4'hA + i[3:0], i != 0});
        end
        @(posedge ref_clk) {wdo, combo} <= 2'h3;
        wr(7'h1B, 8'h8A);
        wr(7'h1A, 8'h6F);
        @(posedge ref_clk) combo <= 0;
        #1 cmp({ctl[9:2], wd_en}, 9'h1FF);
        @(posedge ref_clk) #1;
        cmp(ctl[9:2], 8'hFC);
        wr(7'h11, 8'h0F);
        wr(7'h10, 8'hA5);
        wr(7'h12, 8'hFF);
        @(posedge ref_clk) {pa_pin, sleep} <= {8'h3D, 1'b1};
        #1 cmp({pa_oe, pa_o, pa_pu}, 24'hF0A50F);
        wr(7'h13, 8'h01);
        repeat (3) @(posedge ref_clk);
        rd(7'h10, 8'hAD);
        @(posedge ref_clk) pa_pin <= 8'h3C;
        for (i = 0; i < 8 && wk !== 1'b1; i++) @(posedge ref_clk) #1;
        cmp(wk, 1'b1);
        repeat (2) @(posedge ref_clk);
        complete_run();
    end
endmodule // mscr_regs_tb_top
